// *** design/smac_decoder.sv ***
`timescale 1ns/10ps
// Behaviour
// - Stack-stream select takes one cycle, keeps stack, arms stack-operand streaming.
// - Bus-stream select does the same with the operand taken from the bus.
// - Streamed mode does one multiply-accumulate per clock per item pair.
// - One operand from memory; other from stack list or a bus address.
// - Both stream selects block interrupts so the count instruction follows.
// - Memory read loads next from memory at top, adds literal to top.
// - Streamed memory read also multiplies next by pipeline, accumulates into 48 bits.
// - Accumulator is extension, high and low words; product added across all.
// - Memory read recognised by its fixed encoding; it performs streamed steps.
// - Bus instructions carry a five-bit address reaching 32 locations.
// - Low bus addresses are on-chip; upper addresses go off-chip.
// - Pushing bus read pushes next, top to next, bus data to top, optionally inverted.
// - Pushing ALU bus read pushes, copies top, loads top with ALU result.
// - Keeping bus write sends top, keeps next, optionally inverts top.
// - Popping bus write sends top, next to top optionally inverted, pops into next.
// - Non-pushing ALU bus read replaces top with ALU result, next untouched.
// - Bus ALU codes select the same functions as single-step math codes.
module smac_decoder #(
   parameter int FIFO_DEPTH = 4
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Instruction stream
   input wire logic instr_valid_in,
   input wire logic [15:0] instr_in,
   output logic instr_ready_out,
   // Stack below next
   input wire logic [15:0] pstack_top_in,
   output logic pstack_push_out,
   output logic pstack_pop_out,
   output logic [15:0] pstack_data_out,
   // Peripheral bus
   output smac_pkg::gbus_s gbus_out,
   input wire logic [15:0] gbus_rdata_in,
   // Memory
   output smac_pkg::mem_req_s mem_out,
   input wire logic [15:0] mem_rdata_in,
   // Stream-source address write
   input wire logic src_wr_in,
   input wire logic [4:0] src_addr_in,
   // Core state
   output logic [15:0] top_out,
   output logic [15:0] next_out,
   output logic [47:0] acc_out,
   output logic int_block_out,
   output logic stream_active_out
);
   logic [15:0] top_q, top_d;
   logic [15:0] next_q, next_d;
   logic [47:0] acc_q;
   logic [15:0] count_q;
   logic [4:0] src_q;
   logic src_bus_q;
   smac_pkg::smac_mode_e mode_q;
   smac_pkg::gbus_s gbus_d;
   logic push_d, pop_d;
   logic [15:0] alu_r;
   logic [3:0] cls, alu;
   logic inv, is_asic, is_dma, is_sel, is_cnt, step;
   logic f_valid, f_ready, p_valid;
   logic [15:0] f_data, p_data, p_in;

   initial begin
      if (FIFO_DEPTH < 2) begin
         $error("smac_decoder needs a fifo depth of at least 2");
      end
   end

   assign cls = instr_in[smac_pkg::CLASS_HI:smac_pkg::CLASS_LO];
   assign alu = instr_in[smac_pkg::ALU_HI:smac_pkg::ALU_LO];
   assign inv = instr_in[smac_pkg::INV_BIT];
   assign is_asic = cls == smac_pkg::CLASS_ASIC && !instr_in[smac_pkg::FMT_BIT];
   assign is_dma = instr_in == smac_pkg::OP_DMA;
   assign is_sel = (instr_in & smac_pkg::OP_SMAC_MASK) == smac_pkg::OP_SMACS;
   assign is_cnt = (instr_in & smac_pkg::OP_COUNT_MASK) == smac_pkg::OP_STREAM_COUNT;

   // ****************************************
   // Operand pipeline
   // ****************************************
   // Stack or bus words are staged so the multiplier waits on the source only in the first stream cycle
   assign p_in = src_bus_q ? gbus_rdata_in : pstack_top_in;
   assign p_valid = mode_q == smac_pkg::MODE_STREAM;
   // Without a ready operand the step stalls rather than accumulate garbage
   assign step = instr_valid_in && is_dma && (mode_q != smac_pkg::MODE_STREAM || f_valid);
   assign instr_ready_out = !(mode_q == smac_pkg::MODE_STREAM && is_dma && !f_valid);

   smac_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_pipe (
      .sys_clk_in(sys_clk_in),
      .rst_in(rst_in),
      .in_valid_in(p_valid),
      .in_ready_out(f_ready),
      .in_data_in(p_in),
      .out_valid_out(f_valid),
      // Leftover operands are flushed in normal mode, not while armed or counted, so the next stream starts clean
      .out_ready_in((step && mode_q == smac_pkg::MODE_STREAM) || mode_q == smac_pkg::MODE_NORMAL),
      .out_data_out(f_data)
   );
   assign p_data = f_data;

   // ****************************************
   // ALU
   // ****************************************
   // Shared single-step math encoding
   always_comb begin
      case (alu)
         4'h2: alu_r = top_q & gbus_rdata_in;
         4'h3: alu_r = top_q - gbus_rdata_in;
         4'h4: alu_r = top_q | gbus_rdata_in;
         4'h5: alu_r = top_q + gbus_rdata_in;
         4'h6: alu_r = top_q ^ gbus_rdata_in;
         4'h7: alu_r = gbus_rdata_in - top_q;
         default: alu_r = gbus_rdata_in;
      endcase
   end

   // ****************************************
   // Decode
   // ****************************************
   always_comb begin
      top_d = top_q;
      next_d = next_q;
      push_d = 1'b0;
      pop_d = 1'b0;
      gbus_d = '0;
      if (instr_valid_in && is_dma && step) begin
         next_d = mem_rdata_in;
         top_d = top_q + 16'(instr_in[4:0]);
      end else if (instr_valid_in && is_asic && !is_sel) begin
         gbus_d.addr = instr_in[4:0];
         gbus_d.offchip = instr_in[4:0] >= smac_pkg::OFFCHIP_BASE;
         if (!instr_in[smac_pkg::DIR_BIT]) begin
            gbus_d.rd = 1'b1;
            if (alu == smac_pkg::ALU_PUSH || alu == smac_pkg::ALU_PUSH_N) begin
               push_d = 1'b1;
               next_d = top_q;
               top_d = inv ? ~gbus_rdata_in : gbus_rdata_in;
            end else if (alu[3:1] != 3'b000) begin
               push_d = 1'b1;
               next_d = top_q;
               top_d = alu_r;
            end
         end else begin
            gbus_d.wr = 1'b1;
            gbus_d.data = top_q;
            if (alu == smac_pkg::ALU_PUSH || alu == smac_pkg::ALU_PUSH_N) begin
               pop_d = 1'b1;
               top_d = inv ? ~next_q : next_q;
               next_d = pstack_top_in;
            end else if (alu[3:1] == 3'b000) begin
               top_d = inv ? ~top_q : top_q;
            end else begin
               gbus_d.wr = 1'b0;
               gbus_d.rd = 1'b1;
               top_d = alu_r;
            end
         end
      end
   end

   // ****************************************
   // Stream state
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         mode_q <= smac_pkg::MODE_NORMAL;
         src_bus_q <= 1'b0;
         count_q <= smac_pkg::RESET_WORD;
      end else begin
         case (mode_q)
            smac_pkg::MODE_NORMAL: begin
               if (instr_valid_in && is_sel) begin
                  mode_q <= smac_pkg::MODE_ARMED;
                  src_bus_q <= instr_in[smac_pkg::DIR_BIT];
               end
            end
            smac_pkg::MODE_ARMED: begin
               if (instr_valid_in && is_cnt) begin
                  mode_q <= smac_pkg::MODE_COUNTED;
                  count_q <= next_q;
               end else if (instr_valid_in) begin
                  mode_q <= smac_pkg::MODE_NORMAL;
               end
            end
            smac_pkg::MODE_COUNTED: begin
               if (instr_valid_in) begin
                  mode_q <= is_dma ? smac_pkg::MODE_STREAM : smac_pkg::MODE_NORMAL;
               end
            end
            smac_pkg::MODE_STREAM: begin
               if (step) begin
                  if (count_q == smac_pkg::RESET_WORD) begin
                     mode_q <= smac_pkg::MODE_NORMAL;
                  end else begin
                     count_q <= count_q - 16'h0001;
                  end
               end
            end
            default: mode_q <= smac_pkg::MODE_NORMAL;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         src_q <= 5'h00;
      end else if (src_wr_in) begin
         src_q <= src_addr_in;
      end
   end

   // ****************************************
   // Accumulator
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         acc_q <= smac_pkg::RESET_ACC;
      end else if (step && mode_q == smac_pkg::MODE_STREAM) begin
         acc_q <= acc_q + {16'h0000, 32'(next_q) * 32'(p_data)};
      end
   end

   // ****************************************
   // Registers and outputs
   // ****************************************
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         top_q <= smac_pkg::RESET_WORD;
         next_q <= smac_pkg::RESET_WORD;
      end else begin
         top_q <= top_d;
         next_q <= next_d;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         gbus_out <= '0;
         mem_out <= '0;
         pstack_push_out <= 1'b0;
         pstack_pop_out <= 1'b0;
         pstack_data_out <= smac_pkg::RESET_WORD;
      end else begin
         gbus_out <= gbus_d;
         if (mode_q == smac_pkg::MODE_STREAM && src_bus_q) begin
            gbus_out.addr <= src_q;
            gbus_out.rd <= f_ready;
            gbus_out.offchip <= src_q >= smac_pkg::OFFCHIP_BASE;
         end
         mem_out.addr <= top_d;
         mem_out.rd <= is_dma && instr_valid_in;
         // Stack list drains one word per accepted operand
         pstack_push_out <= push_d;
         pstack_pop_out <= pop_d || (p_valid && f_ready && !src_bus_q);
         pstack_data_out <= next_q;
      end
   end

   assign top_out = top_q;
   assign next_out = next_q;
   assign acc_out = acc_q;
   assign int_block_out = mode_q == smac_pkg::MODE_ARMED;
   assign stream_active_out = mode_q == smac_pkg::MODE_STREAM;

   // ****************************************
   // Checks
   // ****************************************
   property p_sel_block;
      @(posedge sys_clk_in) disable iff (rst_in)
      (mode_q == smac_pkg::MODE_NORMAL && instr_valid_in && is_sel) |=> int_block_out;
   endproperty
   a_sel_block: assert property (p_sel_block) else $error("select did not block interrupts");

   property p_sel_keep;
      @(posedge sys_clk_in) disable iff (rst_in)
      (instr_valid_in && is_sel) |=> $stable(top_q) && $stable(next_q);
   endproperty
   a_sel_keep: assert property (p_sel_keep) else $error("select changed the stack");

   property p_dma_addr;
      @(posedge sys_clk_in) disable iff (rst_in)
      step |=> top_q == $past(top_q) + 16'($past(instr_in[4:0]));
   endproperty
   a_dma_addr: assert property (p_dma_addr) else $error("address not advanced");

   property p_acc;
      @(posedge sys_clk_in) disable iff (rst_in)
      (step && stream_active_out) |=> acc_q == $past(acc_q) + {16'h0000, 32'($past(next_q)) * 32'($past(p_data))};
   endproperty
   a_acc: assert property (p_acc) else $error("accumulate wrong");

   property p_acc_hold;
      @(posedge sys_clk_in) disable iff (rst_in)
      !stream_active_out |=> $stable(acc_q);
   endproperty
   a_acc_hold: assert property (p_acc_hold) else $error("accumulator moved outside stream");

   property p_offchip;
      @(posedge sys_clk_in) disable iff (rst_in)
      (gbus_out.rd || gbus_out.wr) |-> gbus_out.offchip == (gbus_out.addr >= smac_pkg::OFFCHIP_BASE);
   endproperty
   a_offchip: assert property (p_offchip) else $error("off-chip flag wrong");

   property p_push_rd;
      @(posedge sys_clk_in) disable iff (rst_in)
      (push_d && !step) |=> next_q == $past(top_q) && pstack_push_out;
   endproperty
   a_push_rd: assert property (p_push_rd) else $error("push read stack effect wrong");

   property p_pop_wr;
      @(posedge sys_clk_in) disable iff (rst_in)
      (pop_d && !p_valid) |=> gbus_out.wr && gbus_out.data == $past(top_q) && next_q == $past(pstack_top_in);
   endproperty
   a_pop_wr: assert property (p_pop_wr) else $error("pop write wrong");
endmodule : smac_decoder

// *** design/smac_fifo.sv ***
`timescale 1ns/10ps
module smac_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Fill side
   input wire logic in_valid_in,
   output logic in_ready_out,
   input wire logic [WIDTH-1:0] in_data_in,
   // Drain side
   output logic out_valid_out,
   input wire logic out_ready_in,
   output logic [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0] wr_q;
   logic [AW-1:0] rd_q;
   logic [AW:0] cnt_q;
   logic push;
   logic pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin
         $error("smac_fifo depth must be a power of two, at least 2");
      end
   end

   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign in_ready_out = cnt_q != (AW+1)'(DEPTH);
   assign out_valid_out = cnt_q != '0;
   assign out_data_out = mem_q[rd_q];

   always_ff @(posedge sys_clk_in) begin
      if (push) begin
         mem_q[wr_q] <= in_data_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
         cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule : smac_fifo

// *** design/smac_pkg.sv ***
package smac_pkg;
   localparam int DATA_W = 16;
   localparam int ACC_W = 48;
   localparam int GADDR_W = 5;
   // Opcode field positions
   localparam int CLASS_HI = 15;
   localparam int CLASS_LO = 12;
   localparam int ALU_HI = 11;
   localparam int ALU_LO = 8;
   localparam int INV_BIT = 8;
   localparam int DIR_BIT = 7;
   localparam int FMT_BIT = 6;
   localparam int RET_BIT = 5;
   localparam logic [3:0] CLASS_ASIC = 4'hb;
   localparam logic [3:0] ALU_NONE = 4'h0;
   localparam logic [3:0] ALU_PUSH = 4'hf;
   localparam logic [3:0] ALU_PUSH_N = 4'he;
   localparam logic [15:0] OP_DMA = 16'he842;
   // Invert, source and return bits are free in the select encoding
   localparam logic [15:0] OP_SMAC_MASK = 16'hfe5f;
   localparam logic [15:0] OP_SMACS = 16'hb012;
   localparam logic [15:0] OP_SMACA = 16'hb092;
   localparam logic [15:0] OP_STREAM_COUNT = 16'ha000;
   localparam logic [15:0] OP_COUNT_MASK = 16'hf000;
   localparam logic [4:0] OFFCHIP_BASE = 5'h18;
   localparam logic [15:0] RESET_WORD = 16'h0000;
   localparam logic [47:0] RESET_ACC = 48'h0000_0000_0000;

   typedef enum logic [1:0] {
      MODE_NORMAL,
      MODE_ARMED,
      MODE_COUNTED,
      MODE_STREAM
   } smac_mode_e;

   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] data;
      logic wr;
      logic rd;
      logic offchip;
   } gbus_s;

   typedef struct packed {
      logic [15:0] addr;
      logic rd;
   } mem_req_s;
endpackage : smac_pkg

// *** dv/asic_bus_access_streamed_mac_test.sv ***
`timescale 1ns/10ps
module asic_bus_access_streamed_mac_test;
   typedef struct packed {
      logic [15:0] op;
      logic [15:0] t;
      logic [15:0] n;
      logic [15:0] s;
      logic w;
      logic c;
   } row_s;
   localparam logic [15:0] z = 16'h7777;
   localparam logic [15:0] n0 = 16'h1234;
   localparam logic [15:0] t0 = 16'h00ff;
   localparam logic [15:0] d0 = 16'h0ff0;
   // ************
   // Ordinary cases: op, top, next, stack word, write seen, stack checked
   // ************
   row_s rows [14] = '{
      '{16'hbe03, d0, t0, n0, 1'b0, 1'b1}, '{16'hbf04, 16'hf00f, t0, n0, 1'b0, 1'b1},
      '{16'hb203, 16'h00f0, t0, n0, 1'b0, 1'b1}, '{16'hb303, 16'hf10f, t0, n0, 1'b0, 1'b1},
      '{16'hb403, 16'h0fff, t0, n0, 1'b0, 1'b1}, '{16'hb503, 16'h10ef, t0, n0, 1'b0, 1'b1},
      '{16'hb603, 16'h0f0f, t0, n0, 1'b0, 1'b1}, '{16'hb703, 16'h0ef1, t0, n0, 1'b0, 1'b1},
      '{16'hb583, 16'h10ef, n0, z, 1'b0, 1'b1}, '{16'hb083, t0, n0, z, 1'b1, 1'b1},
      '{16'hb197, 16'hff00, n0, z, 1'b1, 1'b1}, '{16'hbe98, n0, z, z, 1'b1, 1'b0},
      '{16'hbf9f, 16'hedcb, z, z, 1'b1, 1'b0}, '{16'he842, 16'h0101, 16'h01ff, z, 1'b0, 1'b1}};
   logic sys_clk_in, rst_in, instr_valid, instr_ready, push, pop, src_wr, int_block, stream_active;
   logic [15:0] instr, pstack_top, pdata, gbus_rdata, mem_rdata, top, next, dev_word;
   logic [4:0] src_addr, last_rd;
   logic [47:0] acc;
   logic [7:0] wr_count, w0;
   smac_pkg::gbus_s gbus, last_wr;
   smac_pkg::mem_req_s mem;
   int err_count, n_checks;
   smac_decoder #(.FIFO_DEPTH(4)) dut (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
      .instr_valid_in(instr_valid), .instr_in(instr), .instr_ready_out(instr_ready),
      .pstack_top_in(pstack_top), .pstack_push_out(push), .pstack_pop_out(pop), .pstack_data_out(pdata),
      .gbus_out(gbus), .gbus_rdata_in(gbus_rdata), .mem_out(mem), .mem_rdata_in(mem_rdata),
      .src_wr_in(src_wr), .src_addr_in(src_addr), .top_out(top), .next_out(next), .acc_out(acc),
      .int_block_out(int_block), .stream_active_out(stream_active));
   smac_partner partner (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .gbus_in(gbus),
      .gbus_rdata_out(gbus_rdata), .dev_word_in(dev_word), .top_in(top), .mem_rdata_out(mem_rdata),
      .push_in(push), .pop_in(pop), .push_data_in(pdata), .stack_word_out(pstack_top),
      .wr_count_out(wr_count), .last_wr_out(last_wr), .last_rd_addr_out(last_rd));
   always #5 sys_clk_in = ~sys_clk_in;
   task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   // Holds the instruction until it has been taken the given number of times
   task automatic run(input logic [15:0] op, input int steps);
      int got;
      int tries;
      logic ok;
      got = 0;
      tries = 0;
      @(negedge sys_clk_in);
      instr = op;
      instr_valid = 1'b1;
      while (got < steps) begin
         #4;
         ok = instr_ready;
         @(posedge sys_clk_in);
         if (ok === 1'b1) got++;
         tries++;
         if (tries > 200) begin
            err_count++;
            end_of_test();
         end
      end
      @(negedge sys_clk_in);
      instr_valid = 1'b0;
      repeat (3) @(negedge sys_clk_in);
   endtask : run
   task automatic push_word(input logic [15:0] d);
      dev_word = d;
      run(16'hbe00, 1);
   endtask : push_word
   task automatic stream(input logic [15:0] sel, input int steps);
      logic [47:0] a;
      for (int i = 0; i < 10; i++) push_word(d0);
      push_word(16'(steps - 1));
      push_word(16'h0040);
      run(sel, 1);
      chk(int_block, 1'b1);
      chk({top, next, pstack_top}, {16'h0040, 16'(steps - 1), d0});
      // Bus operands must carry the same word as the stack list
      dev_word = d0;
      run(smac_pkg::OP_STREAM_COUNT, 1);
      // First read primes next, then one step per item
      run(smac_pkg::OP_DMA, steps + 1);
      repeat (10) @(negedge sys_clk_in);
      a = acc;
      chk({int_block, stream_active}, 2'b00);
      chk(top, 16'h0040 + 16'(2 * (steps + 1)));
      chk(a % d0, 0);
      chk(a == 48'h0000_0000_0000, 1'b0);
      repeat (5) @(negedge sys_clk_in);
      chk(acc, a);
   endtask : stream
   // ************
   // Main sequence
   // ************
   initial begin
      sys_clk_in = 1'b0;
      rst_in = 1'b1;
      instr_valid = 1'b0;
      instr = 16'h0000;
      dev_word = 16'h0000;
      src_wr = 1'b0;
      src_addr = 5'h00;
      err_count = 0;
      n_checks = 0;
      repeat (12) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      rst_in = 1'b0;
      chk({top, next, int_block, stream_active}, 0);
      chk(acc, 0);
      $display("reset test done");
      foreach (rows[k]) begin
         push_word(z);
         push_word(n0);
         push_word(t0);
         dev_word = d0;
         w0 = wr_count;
         run(rows[k].op, 1);
         chk(top, rows[k].t);
         chk(next, rows[k].n);
         if (rows[k].c) chk(pstack_top, rows[k].s);
         chk(8'(wr_count - w0), rows[k].w);
         if (rows[k].w) begin
            chk(last_wr.addr, rows[k].op[4:0]);
            chk(last_wr.data, t0);
            chk(last_wr.offchip, rows[k].op[4:0] >= 5'h18);
         end
         chk(acc, 0);
         $display("row %0d done", k);
      end
      // A foreign instruction after a select drops the armed state
      run(smac_pkg::OP_SMACS, 1);
      run(16'hbe00, 1);
      chk(int_block, 1'b0);
      run(smac_pkg::OP_DMA, 1);
      chk(acc, 0);
      $display("broken sequence test done");
      stream(smac_pkg::OP_SMACS, 4);
      $display("stack stream test done");
      @(negedge sys_clk_in);
      src_wr = 1'b1;
      src_addr = 5'h1a;
      @(negedge sys_clk_in);
      src_wr = 1'b0;
      stream(smac_pkg::OP_SMACA, 3);
      chk(last_rd, 5'h1a);
      $display("bus stream test done");
      end_of_test();
   end
endmodule : asic_bus_access_streamed_mac_test

// *** dv/smac_partner.sv ***
`timescale 1ns/10ps
// ************
// Far side: bus devices, memory, deep stack
// ************
module smac_partner (
   // Clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // Peripheral bus
   input wire smac_pkg::gbus_s gbus_in,
   output logic [15:0] gbus_rdata_out,
   input wire logic [15:0] dev_word_in,
   // Memory, addressed by the current top
   input wire logic [15:0] top_in,
   output logic [15:0] mem_rdata_out,
   // Stack below next
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [15:0] push_data_in,
   output logic [15:0] stack_word_out,
   // Traffic log
   output logic [7:0] wr_count_out,
   output smac_pkg::gbus_s last_wr_out,
   output logic [4:0] last_rd_addr_out
);
   logic [15:0] stk_q [64];
   logic [5:0] sp_q;
   // Device register answers in the same cycle
   assign gbus_rdata_out = dev_word_in;
   // Data tied to its address, so a wrong address shows as wrong data
   assign mem_rdata_out = top_in ^ 16'h0100;
   assign stack_word_out = stk_q[sp_q];
   // Stack wraps like a ring; deep underflow is not modelled
   // One stack area only, so no stack pointer save and restore is needed
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         sp_q <= 6'h00;
      end else if (push_in) begin
         sp_q <= sp_q + 6'h01;
         stk_q[sp_q + 6'h01] <= push_data_in;
      end else if (pop_in) begin
         sp_q <= sp_q - 6'h01;
      end
   end
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         wr_count_out <= 8'h00;
      end else begin
         if (gbus_in.wr) begin
            wr_count_out <= wr_count_out + 8'h01;
            last_wr_out <= gbus_in;
         end
         if (gbus_in.rd) begin
            last_rd_addr_out <= gbus_in.addr;
         end
      end
   end
endmodule : smac_partner
